// File: rtl/clg_core_local_gpio.sv
// Core-local pin-control block with one single-cycle port per core.
`timescale 1ns/1ps
`include "clg_consts.svh"
module clg_core_local_gpio
  import clg_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Core 0 local port
  input wire logic core0Sel,
  input wire logic core0Write,
  input wire logic [31:0] core0Addr,
  input wire logic [31:0] core0WrData,
  output logic core0Ready,
  output logic core0RespValid,
  output logic [31:0] core0RdData,
  // Core 1 local port
  input wire logic core1Sel,
  input wire logic core1Write,
  input wire logic [31:0] core1Addr,
  input wire logic [31:0] core1WrData,
  output logic core1Ready,
  output logic core1RespValid,
  output logic [31:0] core1RdData,
  // User bank pins
  input wire logic [29:0] userPinIn,
  output logic [29:0] userPinOut,
  output logic [29:0] userPinOe_n,
  // Flash bank pins
  input wire logic [5:0] flashPinIn,
  output logic [5:0] flashPinOut,
  output logic [5:0] flashPinOe_n
);

  ////////////////////////////////////////////////////////////////////////////////
  // Local declarations

  localparam int NUM_CORES = 2;
  localparam int NUM_CTRL = 4;

  logic [31:0] portAddr [NUM_CORES];
  logic [31:0] portWrData [NUM_CORES];
  logic portSel [NUM_CORES];
  logic portWrite [NUM_CORES];
  clg_target_t portTarget [NUM_CORES];
  clg_alias_t portAlias [NUM_CORES];
  logic [31:0] rdData_r [NUM_CORES];
  logic [31:0] rdData_nxt [NUM_CORES];
  logic respValid_r [NUM_CORES];

  // Index 0 user level, 1 user enable, 2 flash level, 3 flash enable
  logic [31:0] ctrl_r [NUM_CTRL];
  logic [31:0] ctrl_nxt [NUM_CTRL];

  logic [29:0] userInMeta_r;
  logic [29:0] userInSync_r;
  logic [5:0] flashInMeta_r;
  logic [5:0] flashInSync_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Which target drives control register slot idx
  function automatic clg_target_t ctrlTarget(input int idx);
    clg_target_t t;
    t = TGT_NONE;
    case (idx)
      0: t = TGT_USER_LEVEL;
      1: t = TGT_USER_ENABLE;
      2: t = TGT_FLASH_LEVEL;
      3: t = TGT_FLASH_ENABLE;
      default: t = TGT_NONE;
    endcase
    return t;
  endfunction

  // Valid-bit mask of control register slot idx
  function automatic logic [31:0] ctrlMask(input int idx);
    logic [31:0] m;
    m = `CLG_USER_MASK;
    if (idx >= 2) begin
      m = `CLG_FLASH_MASK;
    end
    return m;
  endfunction

  // Effect of one write through a plain or alias address
  function automatic logic [31:0] applyWrite(input logic [31:0] cur, input clg_alias_t al,
                                             input logic [31:0] data);
    logic [31:0] v;
    v = cur;
    case (al)
      ALIAS_PLAIN: v = data;
      ALIAS_SET: v = cur | data;
      ALIAS_CLEAR: v = cur & ~data;
      ALIAS_TOGGLE: v = cur ^ data;
      default: v = cur;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Port gathering; each core keeps a separate decoder and answer path

  assign portSel[0] = core0Sel;
  assign portSel[1] = core1Sel;
  assign portWrite[0] = core0Write;
  assign portWrite[1] = core1Write;
  assign portAddr[0] = core0Addr;
  assign portAddr[1] = core1Addr;
  assign portWrData[0] = core0WrData;
  assign portWrData[1] = core1WrData;

  // No wait states: a port never stalls except while the block is frozen
  assign core0Ready = clkEn;
  assign core1Ready = clkEn;

  generate
    for (genvar c = 0; c < NUM_CORES; c++) begin : g_port
      clg_port_decode u_decode (
        .sel(portSel[c]),
        .addr(portAddr[c]),
        .target(portTarget[c]),
        .aliasOp(portAlias[c])
      );

      // Read mux; alias addresses and reserved offsets read zero
      always_comb begin
        rdData_nxt[c] = 32'h00000000;
        if (portSel[c] && !portWrite[c]) begin
          case (portTarget[c])
            TGT_CORE_IDENTITY: rdData_nxt[c] = 32'(c);
            TGT_USER_INPUT: rdData_nxt[c] = {2'h0, userInSync_r};
            TGT_FLASH_INPUT: rdData_nxt[c] = {26'h0000000, flashInSync_r};
            TGT_USER_LEVEL,
            TGT_USER_ENABLE,
            TGT_FLASH_LEVEL,
            TGT_FLASH_ENABLE: begin
              if (portAlias[c] == ALIAS_PLAIN) begin
                rdData_nxt[c] = ctrl_r[32'(portTarget[c]) - 32'(TGT_USER_LEVEL)];
              end
            end
            default: rdData_nxt[c] = 32'h00000000;
          endcase
        end
      end

      // Answer lands on the edge after the request
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          rdData_r[c] <= 32'h00000000;
          respValid_r[c] <= 1'b0;
        end else if (clkEn) begin
          rdData_r[c] <= rdData_nxt[c];
          respValid_r[c] <= portSel[c];
        end
      end
    end
  endgenerate

  assign core0RdData = rdData_r[0];
  assign core1RdData = rdData_r[1];
  assign core0RespValid = respValid_r[0];
  assign core1RespValid = respValid_r[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Shared control registers

  // Merge is purely combinational, so only the final value is ever stored
  generate
    for (genvar g = 0; g < NUM_CTRL; g++) begin : g_ctrl
      logic [31:0] afterCore0;
      logic [31:0] afterCore1;

      always_comb begin
        afterCore0 = ctrl_r[g];
        if (portSel[0] && portWrite[0] && portTarget[0] == ctrlTarget(g)) begin
          afterCore0 = applyWrite(ctrl_r[g], portAlias[0], portWrData[0]);
        end
        afterCore1 = afterCore0;
        if (portSel[1] && portWrite[1] && portTarget[1] == ctrlTarget(g)) begin
          afterCore1 = applyWrite(afterCore0, portAlias[1], portWrData[1]);
        end
        ctrl_nxt[g] = afterCore1 & ctrlMask(g);
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_r[g] <= `CLG_CTRL_RESET;
        end else if (clkEn) begin
          ctrl_r[g] <= ctrl_nxt[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Pin input sampling

  // Pins are asynchronous to core_clk; two stages before any read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      userInMeta_r <= 30'h00000000;
      userInSync_r <= 30'h00000000;
    end else if (clkEn) begin
      userInMeta_r <= userPinIn;
      userInSync_r <= userInMeta_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flashInMeta_r <= 6'h00;
      flashInSync_r <= 6'h00;
    end else if (clkEn) begin
      flashInMeta_r <= flashPinIn;
      flashInSync_r <= flashInMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers

  // Pin multiplexer outside must select this function for these to matter
  assign userPinOut = ctrl_r[0][`CLG_USER_PINS-1:0];
  assign userPinOe_n = ~ctrl_r[1][`CLG_USER_PINS-1:0];
  assign flashPinOut = ctrl_r[2][`CLG_FLASH_PINS-1:0];
  assign flashPinOe_n = ~ctrl_r[3][`CLG_FLASH_PINS-1:0];

endmodule

// File: rtl/clg_consts.svh
// Constants of the core-local pin-control block: offsets, fields, reset values.
`ifndef CLG_CONSTS_SVH
`define CLG_CONSTS_SVH

// Segment and window
`define CLG_SEG_BASE 20'hD0000
`define CLG_WIN_TOP 12'h17C

// Register offsets; each output register group is plain, set, clear, toggle
`define CLG_OFS_CORE_IDENTITY 12'h000
`define CLG_OFS_USER_INPUT 12'h004
`define CLG_OFS_FLASH_INPUT 12'h008
`define CLG_OFS_USER_LEVEL 12'h010
`define CLG_OFS_USER_ENABLE 12'h020
`define CLG_OFS_FLASH_LEVEL 12'h030
`define CLG_OFS_FLASH_ENABLE 12'h040

// Bank widths and valid-bit masks
`define CLG_USER_PINS 30
`define CLG_FLASH_PINS 6
`define CLG_USER_MASK 32'h3FFFFFFF
`define CLG_FLASH_MASK 32'h0000003F

// Flash bank bit positions
`define CLG_FLASH_CLK_BIT 0
`define CLG_FLASH_CHIP_SELECT_BIT 1
`define CLG_FLASH_DATA_LINE_ZERO_BIT 2
`define CLG_FLASH_DATA_LINE_THREE_BIT 5

// Reset values
`define CLG_CTRL_RESET 32'h00000000

// Access timing in cycles
`define CLG_ACCESS_CYCLES 1

`endif

// File: rtl/clg_pkg.sv
// Types shared by the core-local pin-control block.
package clg_pkg;

  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_CORE_IDENTITY,
    TGT_USER_INPUT,
    TGT_FLASH_INPUT,
    TGT_USER_LEVEL,
    TGT_USER_ENABLE,
    TGT_FLASH_LEVEL,
    TGT_FLASH_ENABLE
  } clg_target_t;

  typedef enum logic [1:0] {
    ALIAS_PLAIN,
    ALIAS_SET,
    ALIAS_CLEAR,
    ALIAS_TOGGLE
  } clg_alias_t;

endpackage

// File: rtl/clg_port_decode.sv
// Address decoder for one core-local port.
`timescale 1ns/1ps
`include "clg_consts.svh"
module clg_port_decode
  import clg_pkg::*;
(
  // Request
  input wire logic sel,
  input wire logic [31:0] addr,
  // Decoded
  output clg_target_t target,
  output clg_alias_t aliasOp
);

  logic inWindow;

  // Misaligned or out-of-window offsets decode to nothing
  assign inWindow = sel && (addr[31:12] == `CLG_SEG_BASE) && (addr[1:0] == 2'h0)
                    && (addr[11:0] <= `CLG_WIN_TOP);

  always_comb begin
    target = TGT_NONE;
    case (addr[3:2])
      2'h1: aliasOp = ALIAS_SET;
      2'h2: aliasOp = ALIAS_CLEAR;
      2'h3: aliasOp = ALIAS_TOGGLE;
      default: aliasOp = ALIAS_PLAIN;
    endcase
    if (inWindow) begin
      case ({addr[11:4], 4'h0})
        `CLG_OFS_CORE_IDENTITY: begin
          case ({8'h00, addr[3:0]})
            `CLG_OFS_CORE_IDENTITY: target = TGT_CORE_IDENTITY;
            `CLG_OFS_USER_INPUT: target = TGT_USER_INPUT;
            `CLG_OFS_FLASH_INPUT: target = TGT_FLASH_INPUT;
            default: target = TGT_NONE;
          endcase
        end
        `CLG_OFS_USER_LEVEL: target = TGT_USER_LEVEL;
        `CLG_OFS_USER_ENABLE: target = TGT_USER_ENABLE;
        `CLG_OFS_FLASH_LEVEL: target = TGT_FLASH_LEVEL;
        `CLG_OFS_FLASH_ENABLE: target = TGT_FLASH_ENABLE;
        default: target = TGT_NONE;
      endcase
    end
  end

endmodule

// File: verif/clg_pad_model.sv
// Pad model standing between the pin-control block and the board.
`timescale 1ns/1ps
module clg_pad_model (
  // Block side
  input wire logic [29:0] userPinOut,
  input wire logic [29:0] userPinOe_n,
  input wire logic [5:0] flashPinOut,
  input wire logic [5:0] flashPinOe_n,
  // Board side levels seen on undriven pins
  input wire logic [29:0] extUser,
  input wire logic [5:0] extFlash,
  // Resolved pad levels
  output logic [29:0] userPad,
  output logic [5:0] flashPad
);
  // Pin multiplexer taken as always routed to this block
  assign userPad = (userPinOut & ~userPinOe_n) | (extUser & userPinOe_n);
  assign flashPad = (flashPinOut & ~flashPinOe_n) | (extFlash & flashPinOe_n);
endmodule

// File: verif/clg_core_local_gpio_monitor.sv
// Port-level checker for the core-local pin-control block.
`timescale 1ns/1ps
module clg_core_local_gpio_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic core0Sel,
  input wire logic core0Write,
  input wire logic [31:0] core0Addr,
  input wire logic [31:0] core0WrData,
  input wire logic core0Ready,
  input wire logic core0RespValid,
  input wire logic [31:0] core0RdData,
  input wire logic core1Sel,
  input wire logic core1Write,
  input wire logic [31:0] core1Addr,
  input wire logic core1Ready,
  input wire logic [31:0] core1RdData,
  input wire logic [29:0] userPinOut,
  input wire logic [29:0] userPinOe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_no_wait: assert property (core0Ready == clkEn && core1Ready == clkEn)
    else $error("ready does not follow clock enable");
  a_resp_next: assert property (core0Sel && clkEn |=> core0RespValid)
    else $error("core 0 answer missing one cycle after request");
  a_resp_cause: assert property (core0RespValid
    |-> $past(core0Sel && clkEn) || $past(core0RespValid && !clkEn))
    else $error("core 0 answer without request");
  a_ident_one: assert property (core1Sel && !core1Write && core1Addr == 32'hD0000000 && clkEn
    |=> core1RdData == 32'h00000001)
    else $error("core 1 identity wrong");
  a_misalign_zero: assert property (core0Sel && !core0Write && core0Addr[1:0] != 2'h0 && clkEn
    |=> core0RdData == 32'h00000000)
    else $error("misaligned read not zero");
  a_write_rdzero: assert property (core0Sel && core0Write && clkEn |=> core0RdData == 32'h00000000)
    else $error("write answer carries data");
  a_pins_quiet: assert property (!(core0Sel && core0Write) && !(core1Sel && core1Write)
    |=> $stable(userPinOut) && $stable(userPinOe_n))
    else $error("pins moved without a write");
  a_set_alias: assert property (core0Sel && core0Write && clkEn && core0Addr == 32'hD0000014 && !core1Sel
    |=> (userPinOut & $past(core0WrData[29:0])) == $past(core0WrData[29:0]))
    else $error("set alias left a bit low");
endmodule
bind clg_core_local_gpio clg_core_local_gpio_monitor u_mon (.*);

// File: verif/clg_core_local_gpio_tb_top.sv
// Self-checking bench for the core-local pin-control block.
`timescale 1ns/1ps
module clg_core_local_gpio_tb_top;
  localparam logic [31:0] BASE = 32'hD0000000;
  logic core_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  logic core0Sel = 1'b0, core0Write = 1'b0, core1Sel = 1'b0, core1Write = 1'b0;
  logic [31:0] core0Addr = '0, core0WrData = '0, core1Addr = '0, core1WrData = '0;
  logic core0Ready, core0RespValid, core1Ready, core1RespValid;
  logic [31:0] core0RdData, core1RdData, r0, r1, exp;
  logic [29:0] userPinIn, userPinOut, userPinOe_n, extUser = 30'h2AAA5555;
  logic [5:0] flashPinIn, flashPinOut, flashPinOe_n, extFlash = 6'h2D;
  int fail_count = 0, compares = 0;
  initial forever #12.5 core_clk = ~core_clk;
  clg_core_local_gpio u_dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .core0Sel(core0Sel), .core0Write(core0Write), .core0Addr(core0Addr), .core0WrData(core0WrData),
    .core0Ready(core0Ready), .core0RespValid(core0RespValid), .core0RdData(core0RdData),
    .core1Sel(core1Sel), .core1Write(core1Write), .core1Addr(core1Addr), .core1WrData(core1WrData),
    .core1Ready(core1Ready), .core1RespValid(core1RespValid), .core1RdData(core1RdData),
    .userPinIn(userPinIn), .userPinOut(userPinOut), .userPinOe_n(userPinOe_n),
    .flashPinIn(flashPinIn), .flashPinOut(flashPinOut), .flashPinOe_n(flashPinOe_n));
  clg_pad_model u_pad (.userPinOut(userPinOut), .userPinOe_n(userPinOe_n), .flashPinOut(flashPinOut),
    .flashPinOe_n(flashPinOe_n), .extUser(extUser), .extFlash(extFlash), .userPad(userPinIn),
    .flashPad(flashPinIn));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One access on either or both ports; held until ready, answer read just after the taking edge
  task automatic acc(input logic s0, input logic s1, input logic w, input logic [31:0] a0,
    input logic [31:0] a1, input logic [31:0] d0, input logic [31:0] d1);
    @(posedge core_clk);
    core0Sel <= s0;
    core1Sel <= s1;
    core0Write <= w;
    core1Write <= w;
    core0Addr <= a0;
    core1Addr <= a1;
    core0WrData <= d0;
    core1WrData <= d1;
    do @(posedge core_clk); while (core0Ready !== 1'b1);
    core0Sel <= 1'b0;
    core1Sel <= 1'b0;
    #1;
    chk({31'h0, core0RespValid}, {31'h0, s0});
    chk({31'h0, core1RespValid}, {31'h0, s1});
    r0 = core0RdData;
    r1 = core1RdData;
  endtask
  task automatic wrap_up;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    chk({2'h0, userPinOe_n}, 32'h3FFFFFFF);
    chk({2'h0, userPinOut}, 32'h00000000);
    chk({26'h0, flashPinOe_n}, 32'h0000003F);
    rst_n <= 1'b1;
    acc(1, 1, 0, BASE, BASE, 0, 0);
    chk(r0, 32'h00000000);
    chk(r1, 32'h00000001);
    acc(1, 0, 1, BASE + 32'h20, 0, 32'hFFFFFFFF, 0);
    acc(0, 1, 0, 0, BASE + 32'h20, 0, 0);
    chk(r1, 32'h3FFFFFFF);
    chk({2'h0, userPinOe_n}, 32'h00000000);
    exp = 32'h0F0F0F0F;
    acc(1, 0, 1, BASE + 32'h10, 0, exp, 0);
    for (int k = 1; k < 4; k++) begin
      acc(1, 0, 1, BASE + 32'h10 + 32'(4 * k), 0, 32'h3000F0FF, 0);
      exp = (k == 1) ? exp | 32'h3000F0FF : (k == 2) ? exp & ~32'h3000F0FF : exp ^ 32'h3000F0FF;
      chk({2'h0, userPinOut}, exp);
      acc(0, 1, 0, 0, BASE + 32'h10 + 32'(4 * k), 0, 0);
      chk(r1, 32'h00000000);
    end
    acc(1, 0, 1, BASE + 32'h10, 0, 0, 0);
    acc(1, 1, 1, BASE + 32'h14, BASE + 32'h1C, 1, 1);
    chk({2'h0, userPinOut}, 32'h00000000);
    acc(1, 1, 1, BASE + 32'h10, BASE + 32'h10, 5, 6);
    chk({2'h0, userPinOut}, 32'h00000006);
    acc(1, 1, 1, BASE + 32'h28, BASE + 32'h40, 32'h3FFF0000, 32'h00000001);
    repeat (3) @(posedge core_clk);
    acc(1, 1, 0, BASE + 32'h4, BASE + 32'h8, 0, 0);
    chk(r0, 32'h2AAA0006);
    chk(r1, 32'h0000002C);
    acc(1, 0, 1, BASE + 32'h30, 0, 32'hFFFFFFFF, 0);
    acc(1, 0, 0, BASE + 32'h30, 0, 0, 0);
    chk(r0, 32'h0000003F);
    chk({26'h0, flashPinOut}, 32'h0000003F);
    chk({26'h0, flashPinOe_n}, 32'h0000003E);
    acc(1, 1, 0, BASE + 32'h11, BASE + 32'h180, 0, 0);
    chk(r0, 32'h00000000);
    chk(r1, 32'h00000000);
    // Enable low: the write must wait and land only once the block runs again
    @(posedge core_clk);
    clkEn <= 1'b0;
    fork
      begin
        repeat (3) @(posedge core_clk);
        chk({2'h0, userPinOut}, 32'h00000006);
        chk({31'h0, core0Ready}, 32'h00000000);
        clkEn <= 1'b1;
      end
    join_none
    acc(1, 0, 1, BASE + 32'h10, 0, 32'h00000155, 0);
    chk({2'h0, userPinOut}, 32'h00000155);
    // Mid-run reset from driven pins
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({2'h0, userPinOe_n}, 32'h3FFFFFFF);
    chk({26'h0, flashPinOut}, 32'h00000000);
    rst_n <= 1'b1;
    acc(0, 1, 0, 0, BASE + 32'h30, 0, 0);
    chk(r1, 32'h00000000);
    wrap_up();
  end
endmodule
